// >>> host_port_defines.vh
// Command indices, field positions and counts for the parallel host port
`ifndef HOST_PORT_DEFINES_VH
`define HOST_PORT_DEFINES_VH

// ----------------------------------------
// Command byte layout
// ----------------------------------------
`define CMD_WRITE_BIT 7
`define CMD_INDEX_MSB 6
`define CMD_BYTE_MSB 7

// ----------------------------------------
// Host-side register indices kept locally
// ----------------------------------------
`define IDX_DIRECT_START_AND_LENGTH 7'h32
`define IDX_DIRECT_DATA_WINDOW 7'h45
`define IDX_INDIRECT_BYTE_COUNT 7'h22
`define IDX_ASYNC_BUFFER_AREA 7'h40
`define IDX_INTERRUPT_BUFFER_AREA 7'h41
`define IDX_ISO_BUFFER_AREA_0 7'h42
`define IDX_ISO_BUFFER_AREA_1 7'h43

// ----------------------------------------
// Buffer area selectors
// ----------------------------------------
`define AREA_ASYNC 3'h0
`define AREA_INTERRUPT 3'h1
`define AREA_ISO_0 3'h2
`define AREA_ISO_1 3'h3
`define AREA_DIRECT 3'h4
`define AREA_NONE 3'h7

// ----------------------------------------
// Start/length word fields and counts
// ----------------------------------------
`define DSL_START_LSB 1
`define DSL_COUNT_LSB 16
`define DSL_COUNT_MSB 31
`define HALF_WIDTH 16
`define BYTES_PER_WORD 16'h0002
`define COUNT_ZERO 16'h0000

`endif

// >>> pin_sync.v
// Two-flop synchroniser for a bundle of pin inputs
`default_nettype none

module pin_sync #(
    parameter W = 1
) (
    input wire clk_sys,
    input wire resetn,
    input wire ce,
    input wire [W-1:0] pin_in,
    output reg [W-1:0] sync_out
);

    // First stage, read only by the second stage
    reg [W-1:0] stage1_r;

    // ----------------------------------------
    // Two-stage capture
    // ----------------------------------------
    // Resets to ones so idle strobes show no false edge after reset
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            stage1_r <= {W{1'b1}};
            sync_out <= {W{1'b1}};
        end else if (ce) begin
            stage1_r <= pin_in;
            sync_out <= stage1_r;
        end
    end

endmodule

`default_nettype wire

// >>> word_buffer2.v
// Two-entry valid/ready buffer with a registered head word
`default_nettype none

module word_buffer2 #(
    parameter W = 17
) (
    input wire clk_sys,
    input wire resetn,
    input wire ce,
    input wire [W-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output reg [W-1:0] out_data,
    output reg out_valid,
    input wire out_ready
);

    // Second slot and its valid flag
    reg [W-1:0] slot1_r;
    reg slot1_valid_r;
    wire push;
    wire pop;

    // Full only when both slots hold a word
    assign in_ready = ~slot1_valid_r;
    assign push = in_valid & ~slot1_valid_r;
    assign pop = out_valid & out_ready;

    // ----------------------------------------
    // Shift buffer: head always in out_data
    // ----------------------------------------
    // Keeping the head in place lets the consumer see a flop output
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            out_data <= {W{1'b0}};
            out_valid <= 1'b0;
            slot1_r <= {W{1'b0}};
            slot1_valid_r <= 1'b0;
        end else if (ce) begin
            if (pop) begin
                // Second slot moves up and empties; no incoming word is accepted while it is full
                if (slot1_valid_r) begin
                    out_data <= slot1_r;
                    out_valid <= 1'b1;
                    slot1_valid_r <= push;
                    slot1_r <= in_data;
                end else begin
                    out_data <= in_data;
                    out_valid <= push;
                end
            end else if (push) begin
                // Fill the first free slot
                if (!out_valid) begin
                    out_data <= in_data;
                    out_valid <= 1'b1;
                end else begin
                    slot1_r <= in_data;
                    slot1_valid_r <= 1'b1;
                end
            end
        end
    end

endmodule

`default_nettype wire

// >>> host_pio_dma_bus_port.v
// Parallel processor port: command/data pairs, buffer memory access, slave DMA
`include "host_port_defines.vh"
`default_nettype none

module host_pio_dma_bus_port #(
    parameter AW = 11,
    parameter MEM_WORDS = 2048
) (
    input wire clk_sys,
    input wire resetn,
    input wire ce,
    input wire cs_n,
    input wire rd_n,
    input wire wr_n,
    input wire unit_select_line,
    input wire phase_select_line,
    input wire [15:0] data_in,
    output reg [15:0] data_out,
    output reg data_oe_n,
    output reg host_dma_request,
    input wire host_dma_ack_n,
    output reg periph_dma_request,
    input wire periph_dma_ack_n,
    input wire host_dma_enable,
    input wire [2:0] host_dma_area,
    input wire periph_dma_enable,
    input wire [AW-1:0] area_base_async,
    input wire [AW-1:0] area_base_interrupt,
    input wire [AW-1:0] area_base_iso_0,
    input wire [AW-1:0] area_base_iso_1,
    output reg transfer_done,
    output reg [6:0] host_reg_index,
    output reg [15:0] host_reg_wdata,
    output reg host_reg_write,
    output reg host_reg_read,
    output reg host_reg_half,
    input wire [15:0] host_reg_rdata,
    output wire [16:0] periph_word,
    output wire periph_word_valid,
    input wire periph_word_ready,
    output reg periph_read,
    input wire [15:0] periph_rd_data
);

    // ----------------------------------------
    // Pin synchronisation
    // ----------------------------------------
    wire [22:0] pins_s;
    wire cs_s;
    wire rd_s;
    wire wr_s;
    wire a1_s;
    wire a0_s;
    wire ack1_s;
    wire ack2_s;
    wire [15:0] din_s;

    // All strobes, selects and data pass two flops
    pin_sync #(.W(23)) u_sync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ce(ce),
        .pin_in({cs_n, rd_n, wr_n, unit_select_line, phase_select_line,
                 host_dma_ack_n, periph_dma_ack_n, data_in}),
        .sync_out(pins_s)
    );

    assign {cs_s, rd_s, wr_s, a1_s, a0_s, ack1_s, ack2_s, din_s} = pins_s;

    // ----------------------------------------
    // State
    // ----------------------------------------
    reg rd_prev_r;                 // Strobe history for edge detect
    reg wr_prev_r;
    reg [7:0] cmd_r;               // Last host command byte
    reg half_r;                    // Next data phase is upper half
    reg [31:0] dsl_r;              // Direct start address and length
    reg [15:0] byte_count_r;       // Shared indirect byte count
    reg [AW-1:0] ptr_r;            // Buffer word pointer
    reg [15:0] remaining_r;        // Bytes left in current access run
    reg dma1_active_r;             // Channel one run in progress
    reg dma_en_prev_r;             // Enable history for start edge
    reg [15:0] mem [0:MEM_WORDS-1]; // Host buffer memory

    // ----------------------------------------
    // Index decoding helpers
    // ----------------------------------------
    // Maps a command index to the buffer area it opens, if any
    function [2:0] area_of;
        input [6:0] idx;
        begin
            if (idx == `IDX_DIRECT_DATA_WINDOW)
                area_of = `AREA_DIRECT;
            else if (idx == `IDX_ASYNC_BUFFER_AREA)
                area_of = `AREA_ASYNC;
            else if (idx == `IDX_INTERRUPT_BUFFER_AREA)
                area_of = `AREA_INTERRUPT;
            else if (idx == `IDX_ISO_BUFFER_AREA_0)
                area_of = `AREA_ISO_0;
            else if (idx == `IDX_ISO_BUFFER_AREA_1)
                area_of = `AREA_ISO_1;
            else
                area_of = `AREA_NONE;
        end
    endfunction

    // Start word of an area; direct uses the programmed byte address
    function [AW-1:0] start_of;
        input [2:0] area;
        begin
            if (area == `AREA_DIRECT)
                start_of = dsl_r[AW:`DSL_START_LSB];
            else if (area == `AREA_INTERRUPT)
                start_of = area_base_interrupt;
            else if (area == `AREA_ISO_0)
                start_of = area_base_iso_0;
            else if (area == `AREA_ISO_1)
                start_of = area_base_iso_1;
            else
                start_of = area_base_async;
        end
    endfunction

    // Length of a run: direct has its own count, areas share one
    function [15:0] length_of;
        input [2:0] area;
        begin
            if (area == `AREA_DIRECT)
                length_of = dsl_r[`DSL_COUNT_MSB:`DSL_COUNT_LSB];
            else
                length_of = byte_count_r;
        end
    endfunction

    // ----------------------------------------
    // Access qualification
    // ----------------------------------------
    wire sel = ~cs_s;
    wire rd_fall = rd_prev_r & ~rd_s;
    wire wr_fall = wr_prev_r & ~wr_s;
    wire strobe = rd_fall | wr_fall;
    wire [6:0] cmd_idx = cmd_r[`CMD_INDEX_MSB:0];
    wire cmd_is_write = cmd_r[`CMD_WRITE_BIT];
    wire [2:0] cmd_area = area_of(cmd_idx);
    wire clash = host_dma_request & periph_dma_request & ~ack1_s & ~ack2_s;
    // Select overrides acknowledges; request gates ack
    wire dma1_sel = ~sel & ~clash & host_dma_request & ~ack1_s;
    wire dma2_sel = ~sel & ~clash & periph_dma_request & ~ack2_s;
    wire host_data = sel & ~a1_s & ~a0_s;
    wire host_cmd = sel & ~a1_s & a0_s;
    wire periph_data = sel & a1_s & ~a0_s;
    wire periph_cmd = sel & a1_s & a0_s;
    wire host_buf_hit = (host_data & (cmd_area != `AREA_NONE) | dma1_sel) & strobe;
    wire buf_go = host_buf_hit & (remaining_r != `COUNT_ZERO);
    wire last_word = remaining_r <= `BYTES_PER_WORD;
    wire host_reg_hit = host_data & (cmd_area == `AREA_NONE) & strobe;
    wire start_dma = host_dma_enable & ~dma_en_prev_r;

    // Peripheral side stream: commands tagged with bit 16
    wire push_valid;
    wire push_ready;
    wire [16:0] push_word;

    // Peripheral command and data writes queued
    assign push_valid = wr_fall & (periph_cmd | periph_data | dma2_sel);
    assign push_word = {periph_cmd, din_s};

    // Buffer absorbs one stall cycle; a full buffer drops the request
    word_buffer2 #(.W(17)) u_buf (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ce(ce),
        .in_data(push_word),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .out_data(periph_word),
        .out_valid(periph_word_valid),
        .out_ready(periph_word_ready)
    );

    // ----------------------------------------
    // Host buffer memory
    // ----------------------------------------
    // Write on a buffer write strobe at the current pointer
    always @(posedge clk_sys) begin
        if (ce && buf_go && wr_fall) begin
            mem[ptr_r] <= din_s;
        end
    end

    // ----------------------------------------
    // Main sequencer
    // ----------------------------------------
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rd_prev_r <= 1'b1;
            wr_prev_r <= 1'b1;
            cmd_r <= 8'h00;
            half_r <= 1'b0;
            dsl_r <= 32'h0000_0000;
            byte_count_r <= 16'h0000;
            ptr_r <= {AW{1'b0}};
            remaining_r <= 16'h0000;
            dma1_active_r <= 1'b0;
            dma_en_prev_r <= 1'b0;
            data_out <= 16'h0000;
            data_oe_n <= 1'b1;
            host_dma_request <= 1'b0;
            periph_dma_request <= 1'b0;
            transfer_done <= 1'b0;
            host_reg_index <= 7'h00;
            host_reg_wdata <= 16'h0000;
            host_reg_write <= 1'b0;
            host_reg_read <= 1'b0;
            host_reg_half <= 1'b0;
            periph_read <= 1'b0;
        end else if (ce) begin
            rd_prev_r <= rd_s;
            wr_prev_r <= wr_s;
            dma_en_prev_r <= host_dma_enable;
            // Pulses default low
            transfer_done <= 1'b0;
            host_reg_write <= 1'b0;
            host_reg_read <= 1'b0;
            periph_read <= 1'b0;

            data_oe_n <= ~(~rd_s & ~clash & (host_data | periph_data | dma1_sel | dma2_sel));

            // Channel two request follows enable and space
            periph_dma_request <= periph_dma_enable & push_ready;

            if (host_cmd && wr_fall) begin
                cmd_r <= din_s[`CMD_BYTE_MSB:0];
                half_r <= 1'b0;
                if (area_of(din_s[`CMD_INDEX_MSB:0]) != `AREA_NONE) begin
                    ptr_r <= start_of(area_of(din_s[`CMD_INDEX_MSB:0]));
                    remaining_r <= length_of(area_of(din_s[`CMD_INDEX_MSB:0]));
                end
            end else if (start_dma && !dma1_active_r) begin
                // Channel one loads host buffer run
                ptr_r <= start_of(host_dma_area);
                remaining_r <= length_of(host_dma_area);
                dma1_active_r <= 1'b1;
                host_dma_request <= length_of(host_dma_area) != `COUNT_ZERO;
            end else if (buf_go) begin
                ptr_r <= ptr_r + {{(AW-1){1'b0}}, 1'b1};
                remaining_r <= remaining_r - `BYTES_PER_WORD;
                if (rd_fall) begin
                    data_out <= mem[ptr_r];
                end
                if (dma1_sel && last_word) begin
                    host_dma_request <= 1'b0;
                    dma1_active_r <= 1'b0;
                    transfer_done <= 1'b1;
                end
            end else if (host_reg_hit) begin
                half_r <= ~half_r;
                if (wr_fall && cmd_is_write) begin
                    if (cmd_idx == `IDX_DIRECT_START_AND_LENGTH) begin
                        if (half_r)
                            dsl_r[31:16] <= din_s;
                        else
                            dsl_r[15:0] <= din_s;
                    // One count shared by all four indirect areas
                    end else if (cmd_idx == `IDX_INDIRECT_BYTE_COUNT) begin
                        byte_count_r <= din_s;
                    end else begin
                        host_reg_index <= cmd_idx;
                        host_reg_wdata <= din_s;
                        host_reg_half <= half_r;
                        host_reg_write <= 1'b1;
                    end
                end else if (rd_fall && !cmd_is_write) begin
                    // Reads use the phase to pick the half
                    if (cmd_idx == `IDX_DIRECT_START_AND_LENGTH) begin
                        data_out <= half_r ? dsl_r[31:16] : dsl_r[15:0];
                    end else if (cmd_idx == `IDX_INDIRECT_BYTE_COUNT) begin
                        data_out <= byte_count_r;
                    end else begin
                        data_out <= host_reg_rdata;
                        host_reg_index <= cmd_idx;
                        host_reg_half <= half_r;
                        host_reg_read <= 1'b1;
                    end
                end
            end

            // Channel one dropped when software disables it
            if (!host_dma_enable && dma1_active_r) begin
                dma1_active_r <= 1'b0;
                host_dma_request <= 1'b0;
            end

            // Peripheral reads take word from peripheral logic
            if (rd_fall && (periph_data || dma2_sel)) begin
                data_out <= periph_rd_data;
                periph_read <= 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// >>> host_port_properties.sv
// Timing checks on the parallel host port, bound to its top module
`default_nettype none

module host_port_properties (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic unit_select_line,
    input wire logic phase_select_line,
    input wire logic data_oe_n,
    input wire logic host_reg_write,
    input wire logic host_reg_read,
    input wire logic host_reg_half,
    input wire logic periph_read,
    input wire logic transfer_done,
    input wire logic host_dma_request,
    input wire logic host_dma_enable,
    input wire logic periph_dma_request,
    input wire logic periph_dma_enable,
    input wire logic [16:0] periph_word,
    input wire logic periph_word_valid,
    input wire logic periph_word_ready
);
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------
    // One clock domain, reset disables all
    // ----------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    // Two sync flops plus the output flop put causes three samples back
    property p_oe_cause;
        $fell(data_oe_n) |-> $past(!rd_n, 3) && ($past(cs_n, 3) || !$past(phase_select_line, 3));
    endproperty
    a_oe_cause: assert property (p_oe_cause)
        else $error("bus driven without a data port read");
    property p_wr_cause;
        host_reg_write |-> $past(!wr_n, 3) && !$past(cs_n, 3) && !$past(unit_select_line, 3)
            && !$past(phase_select_line, 3);
    endproperty
    a_wr_cause: assert property (p_wr_cause)
        else $error("register write pulse without host data write");
    property p_rd_cause;
        host_reg_read |-> $past(!rd_n, 3) && !$past(cs_n, 3) && !$past(unit_select_line, 3)
            && !$past(phase_select_line, 3);
    endproperty
    a_rd_cause: assert property (p_rd_cause)
        else $error("register read pulse without host data read");
    // Peripheral reads come from the peripheral data port or, on channel two, with chip select high
    property p_periph_rd;
        periph_read |-> $past(!rd_n, 3) && ($past(cs_n, 3)
            || $past(unit_select_line, 3) && !$past(phase_select_line, 3));
    endproperty
    a_periph_rd: assert property (p_periph_rd)
        else $error("peripheral read pulse without peripheral data read");
    property p_done_ends;
        transfer_done |-> !host_dma_request && $past(host_dma_request);
    endproperty
    a_done_ends: assert property (p_done_ends)
        else $error("end of transfer without dropping the request");
    property p_done_pulse;
        transfer_done |=> !transfer_done;
    endproperty
    a_done_pulse: assert property (p_done_pulse)
        else $error("end of transfer longer than one cycle");
    property p_req_rise;
        $rose(host_dma_request) |-> $past(host_dma_enable);
    endproperty
    a_req_rise: assert property (p_req_rise)
        else $error("channel one request without enable");
    property p_periph_req;
        periph_dma_request |-> $past(periph_dma_enable);
    endproperty
    a_periph_req: assert property (p_periph_req)
        else $error("channel two request without enable");
    property p_word_hold;
        periph_word_valid && !periph_word_ready |=> periph_word_valid && $stable(periph_word);
    endproperty
    a_word_hold: assert property (p_word_hold)
        else $error("stalled peripheral word changed or vanished");

    // ----------------------------------------
    // Main scenarios reached
    // ----------------------------------------
    c_high_half: cover property (host_reg_write && host_reg_half);
    c_done: cover property (transfer_done);
    c_stall: cover property (periph_word_valid && !periph_word_ready);
endmodule

bind host_pio_dma_bus_port host_port_properties u_props (
    .clk_sys(clk_sys), .resetn(resetn), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .unit_select_line(unit_select_line), .phase_select_line(phase_select_line),
    .data_oe_n(data_oe_n), .host_reg_write(host_reg_write), .host_reg_read(host_reg_read),
    .periph_read(periph_read), .transfer_done(transfer_done), .host_reg_half(host_reg_half),
    .host_dma_request(host_dma_request), .host_dma_enable(host_dma_enable),
    .periph_dma_request(periph_dma_request), .periph_dma_enable(periph_dma_enable),
    .periph_word(periph_word), .periph_word_valid(periph_word_valid),
    .periph_word_ready(periph_word_ready)
);

`default_nettype wire

// >>> periph_stream_sink.sv
// Consumer of the peripheral word stream, stalling at random
`default_nettype none

module periph_stream_sink (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic stall,
    input wire logic [16:0] periph_word,
    input wire logic periph_word_valid,
    output logic periph_word_ready,
    output logic taken_valid,
    output logic [16:0] taken_word
);
    timeunit 1ns;
    timeprecision 100ps;

    // Ready drops on request and one cycle in four, so slow drains occur
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            periph_word_ready <= 1'b0;
            taken_valid <= 1'b0;
            taken_word <= 17'h0_0000;
        end else begin
            taken_valid <= periph_word_valid & periph_word_ready;
            taken_word <= periph_word;
            periph_word_ready <= !stall && ($urandom_range(3) != 0);
        end
    end
endmodule

`default_nettype wire

// >>> host_pio_dma_bus_port_test.sv
// Self-checking bench for the parallel host port
`default_nettype none

module host_pio_dma_bus_port_test;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk_sys = 1'b0, resetn = 1'b0, ce = 1'b1, cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1;
    logic unit_select_line = 1'b0, phase_select_line = 1'b0, host_dma_ack_n = 1'b1;
    logic periph_dma_ack_n = 1'b1, host_dma_enable = 1'b0, periph_dma_enable = 1'b0;
    logic stall = 1'b1;
    logic [15:0] data_in = 16'h0000, host_reg_rdata = 16'h0000, periph_rd_data = 16'h0000;
    logic [2:0] host_dma_area = 3'h0;
    logic [10:0] base [0:3] = '{11'h100, 11'h140, 11'h000, 11'h080};
    logic [10:0] area_base_async, area_base_interrupt, area_base_iso_0, area_base_iso_1;
    logic [15:0] data_out, host_reg_wdata, last_rd = 16'h0000;
    logic [15:0] w [0:3];
    logic [6:0] host_reg_index;
    logic [16:0] periph_word, taken_word;
    logic data_oe_n, host_dma_request, periph_dma_request, transfer_done, host_reg_write;
    logic host_reg_read, host_reg_half, periph_word_valid, periph_word_ready, periph_read;
    logic taken_valid;
    logic [31:0] rv;
    logic [23:0] wq [$];
    logic [16:0] rq [$];
    logic [16:0] pq [$];
    int failures = 0, checks = 0, done_seen = 0, i;

    assign area_base_async = base[0];
    assign area_base_interrupt = base[1];
    assign area_base_iso_0 = base[2];
    assign area_base_iso_1 = base[3];

    host_pio_dma_bus_port u_dut (.*);
    periph_stream_sink u_sink (.*);

    // ----------------------------------------
    // Clock, comparison and closing
    // ----------------------------------------
    initial forever #12.5 clk_sys = ~clk_sys;

    task check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task tally_and_finish;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // One strobe cycle; low six clocks so the two-flop sync sees it
    task automatic cyc(input logic c, u, p, a, r, input logic [15:0] d);
        @(posedge clk_sys);
        cs_n <= c;
        unit_select_line <= u;
        phase_select_line <= p;
        host_dma_ack_n <= a;
        data_in <= d;
        if (r) rd_n <= 1'b0;
        else wr_n <= 1'b0;
        repeat (6) @(posedge clk_sys);
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        repeat (5) @(posedge clk_sys);
        cs_n <= 1'b1;
        host_dma_ack_n <= 1'b1;
    endtask

    // Command index in the low byte, upper byte zero
    // command word layout
    task automatic cmd(input logic u, input logic [7:0] c);
        cyc(1'b0, u, 1'b1, 1'b1, 1'b0, {8'h00, c});
    endtask

    task automatic wrd(input logic u, input logic [15:0] d);
        cyc(1'b0, u, 1'b0, 1'b1, 1'b0, d);
    endtask

    // Undriven reads leave the bus released and the old word held
    task automatic rdd(input logic u, p, input logic [15:0] e, input logic drv);
        rq.push_back(drv ? {1'b0, e} : {1'b1, last_rd});
        if (drv) last_rd = e;
        cyc(1'b0, u, p, 1'b1, 1'b1, 16'h0000);
    endtask

    task automatic direct(input logic [15:0] start, cnt, input logic [7:0] op);
        cmd(1'b0, 8'hB2);
        wrd(1'b0, start);
        wrd(1'b0, cnt);
        cmd(1'b0, op);
    endtask

    // ----------------------------------------
    // Watchers of the outputs
    // ----------------------------------------
    always @(negedge clk_sys) begin
        if (host_reg_write === 1'b1)
            check({host_reg_index, host_reg_half, host_reg_wdata},
                wq.size() ? wq.pop_front() : 24'hFF_FFFF);
        if (taken_valid === 1'b1)
            check(taken_word, pq.size() ? pq.pop_front() : 17'h1_FFFF);
        if (transfer_done === 1'b1) done_seen++;
    end

    // Read results compared as the strobe is released
    always @(posedge rd_n) begin
        if (rq.size() != 0) check({data_oe_n, data_out}, rq.pop_front());
    end

    initial begin
        #200_000;
        failures++;
        tally_and_finish;
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(71241));
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1 check({data_oe_n, host_dma_request, periph_dma_request, transfer_done}, 32'h8);
        // Wide write in two halves, then a write after a read command
        rv = $urandom;
        cmd(1'b0, 8'h90);
        wq.push_back({7'h10, 1'b0, rv[15:0]});
        wrd(1'b0, rv[15:0]);
        wq.push_back({7'h10, 1'b1, rv[31:16]});
        wrd(1'b0, rv[31:16]);
        cmd(1'b0, 8'h10);
        wrd(1'b0, rv[15:0]);
        host_reg_rdata <= rv[31:16];
        rdd(1'b0, 1'b0, rv[31:16], 1'b1);
        host_reg_rdata <= ~rv[15:0];
        rdd(1'b0, 1'b0, ~rv[15:0], 1'b1);
        rdd(1'b0, 1'b1, 16'h0000, 1'b0);
        rdd(1'b1, 1'b1, 16'h0000, 1'b0);
        // Direct window: four words written, then read from the same start
        direct(16'h0010, 16'h0008, 8'hC5);
        for (i = 0; i < 4; i++) begin
            w[i] = $urandom;
            wrd(1'b0, w[i]);
        end
        direct(16'h0010, 16'h0008, 8'h45);
        for (i = 0; i < 4; i++) rdd(1'b0, 1'b0, w[i], 1'b1);
        // Each indirect area gets one word at its offset zero
        for (i = 0; i < 4; i++) begin
            cmd(1'b0, 8'hA2);
            wrd(1'b0, 16'h0002);
            cmd(1'b0, 8'hC0 + i[7:0]);
            w[i] = $urandom;
            wrd(1'b0, w[i]);
        end
        for (i = 0; i < 4; i++) begin
            direct({4'h0, base[i], 1'b0}, 16'h0002, 8'h45);
            rdd(1'b0, 1'b0, w[i], 1'b1);
        end
        // Acknowledge while no request is up must be ignored
        rq.push_back({1'b1, last_rd});
        cyc(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0000);
        // Channel one run of two words into the async area
        cmd(1'b0, 8'hA2);
        wrd(1'b0, 16'h0004);
        host_dma_enable <= 1'b1;
        for (i = 0; i < 4 && host_dma_request !== 1'b1; i++) @(posedge clk_sys);
        #1 check(host_dma_request, 1);
        // Selected command-port read with ack low: ack must be ignored
        rq.push_back({1'b1, last_rd});
        cyc(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 16'h0000);
        for (i = 0; i < 2; i++) begin
            w[i] = $urandom;
            cyc(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, w[i]);
        end
        #1 check({host_dma_request, done_seen[3:0]}, 32'h1);
        host_dma_enable <= 1'b0;
        direct(16'h0200, 16'h0004, 8'h45);
        for (i = 0; i < 2; i++) rdd(1'b0, 1'b0, w[i], 1'b1);
        // Peripheral stream: sink stalled, buffer fills and refuses a third word
        periph_dma_enable <= 1'b1;
        for (i = 0; i < 3; i++) begin
            w[i] = $urandom & 16'h00FF;
            if (i < 2) pq.push_back({~i[0], w[i]});
            cyc(1'b0, 1'b1, ~i[0], 1'b1, 1'b0, w[i]);
        end
        #1 check(periph_dma_request, 0);
        stall <= 1'b0;
        repeat (20) @(posedge clk_sys);
        #1 check({periph_word_valid, periph_dma_request}, 32'h1);
        // Both channels requested and acknowledged: bus stays off
        host_dma_enable <= 1'b1;
        periph_dma_ack_n <= 1'b0;
        rq.push_back({1'b1, last_rd});
        cyc(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0000);
        periph_dma_ack_n <= 1'b1;
        rv = $urandom;
        periph_rd_data <= rv[15:0];
        rdd(1'b1, 1'b0, rv[15:0], 1'b1);
        check(wq.size() + pq.size() + rq.size(), 0);
        tally_and_finish;
    end
endmodule

`default_nettype wire
